// file: acc_top.sv
// analog comparator control: registers, input routing, sync and event flag
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps

// What this block does
// - result bit is one when positive input exceeds negative input.
// - mux enabled, converter off: channel code 0..7 picks converter pin.
// - mux disabled or converter on: dedicated negative pin is used.
// - bandgap select replaces positive pin by the bandgap reference.
// - comparator output is synchronised, one to two cycles latency.
// - edge mode: 00 toggle, 01 reserved, 10 falling, 11 rising.
// - hardware sets the event flag on the selected event.
// - interrupt request only when flag, enable and global enable are one.
// - taking the interrupt vector clears the event flag.
// - writing one to the flag clears it; zero leaves it.
// - power-off bit switches the comparator off at any time.
// - capture route bit feeds the comparator into the timer capture.
// - buffer disable bit turns off pin input; its read bit is zero.
// - converter enable powers converter; mux uses selection only when clear.
module acc_top #(
  parameter int NUM_PINS = 8
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite slave
  input  wire logic [acc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [acc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // analog front end and cpu
  input  wire logic                         cmp_raw,
  input  wire logic                         global_irq_enable,
  input  wire logic                         irq_vector_taken,
  input  wire logic [NUM_PINS-1:0]          pin_in,
  output logic [NUM_PINS-1:0]               pin_read,
  output logic [NUM_PINS-1:0]               digital_buffer_off,
  output acc_pkg::acc_route_t               route,
  output logic                              converter_enable,
  output logic                              capture_in,
  output logic                              cmp_irq
);

  // ****************************************
  // registers
  // ****************************************
  logic [NUM_PINS-1:0]  dig_dis_r;
  logic [7:0]           conv_ctl_b_r;
  logic [7:0]           conv_sel_r;
  acc_pkg::acc_cmp_ctl_t cmp_ctl_r;
  logic                 flag_r;
  logic                 flag_nxt;
  logic [NUM_PINS-1:0]  pin_read_r;
  acc_pkg::acc_route_t  route_r;
  acc_pkg::acc_route_t  route_nxt;
  logic                 capture_r;
  logic                 irq_r;

  // bus state
  logic                       awready_r;
  logic                       wready_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic [acc_pkg::ADDR_W-1:0] awaddr_r;
  logic [7:0]                 wbyte_r;
  logic                       wlane_r;
  // holders: full from their take until the response is raised
  logic                       aw_got_r;
  logic                       w_got_r;
  logic                       arready_r;
  logic                       rvalid_r;
  logic [31:0]                rdata_r;
  logic [1:0]                 rresp_r;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic is_mapped(input logic [acc_pkg::ADDR_W-1:0] a);
    is_mapped = (a == acc_pkg::DIG_IN_DIS_ADDR) || (a == acc_pkg::CONV_CTL_B_ADDR) ||
                (a == acc_pkg::CMP_CTL_STS_ADDR) || (a == acc_pkg::CONV_SEL_ADDR);
  endfunction : is_mapped

  // address and data may come in either order; each waits in its own holder
  wire aw_take  = s_axi_awvalid & awready_r;
  wire w_take   = s_axi_wvalid & wready_r;
  wire b_free   = ~bvalid_r | s_axi_bready;
  wire wr_fire  = aw_got_r & w_got_r & ~bvalid_r;
  // lane 0 strobe low: the write is answered but changes nothing
  wire wr_en    = wr_fire & wlane_r;
  wire wr_dig   = wr_en & (awaddr_r == acc_pkg::DIG_IN_DIS_ADDR);
  wire wr_convb = wr_en & (awaddr_r == acc_pkg::CONV_CTL_B_ADDR);
  wire wr_cmp   = wr_en & (awaddr_r == acc_pkg::CMP_CTL_STS_ADDR);
  wire wr_csel  = wr_en & (awaddr_r == acc_pkg::CONV_SEL_ADDR);
  wire ar_take  = s_axi_arvalid & arready_r;

  // ****************************************
  // comparator path
  // ****************************************
  logic cmp_sync;
  logic cmp_event;
  // a powered-off comparator reads low; the change can look like an edge
  wire  cmp_gated = cmp_raw & ~cmp_ctl_r.power_off;

  acc_sync #(
    .STAGES (acc_pkg::SYNC_STAGES)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (cmp_gated),
    .dout    (cmp_sync)
  );

  // result bit and events both come from the synchronised copy
  acc_edge u_edge (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .level       (cmp_sync),
    .mode        (cmp_ctl_r.edge_mode_field),
    .event_pulse (cmp_event)
  );

  // set wins over both clears
  wire flag_clr = (wr_cmp & wbyte_r[acc_pkg::FLAG_BIT]) | irq_vector_taken;
  assign flag_nxt = cmp_event | (flag_r & ~flag_clr);

  // ****************************************
  // input routing
  // ****************************************
  wire conv_on  = conv_sel_r[acc_pkg::CONV_EN_BIT];
  wire [4:0] chan = conv_sel_r[acc_pkg::CHAN_SEL_LSB +: 5];
  // codes above seven fall back to the dedicated pin
  wire use_conv = conv_ctl_b_r[acc_pkg::NEG_MUX_EN_BIT] & ~conv_on &
                  (chan <= acc_pkg::CHAN_LAST);

  // route is registered so the analog switches see one change per cycle
  always_comb begin
    route_nxt.neg_from_converter = use_conv;
    route_nxt.neg_channel        = chan[2:0];
    route_nxt.pos_from_bandgap   = cmp_ctl_r.bandgap_select;
    route_nxt.cmp_power_off      = cmp_ctl_r.power_off;
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dig_dis_r    <= '0;
      conv_ctl_b_r <= acc_pkg::CONV_CTL_B_RST;
      conv_sel_r   <= 8'h00;
      cmp_ctl_r    <= '0;
      flag_r       <= 1'b0;
    end else begin
      if (wr_dig) begin
        dig_dis_r <= wbyte_r[NUM_PINS-1:0];
      end
      // reserved bits read back zero through the write masks
      if (wr_convb) begin
        conv_ctl_b_r <= wbyte_r & acc_pkg::CONV_CTL_B_MASK;
      end
      if (wr_csel) begin
        conv_sel_r <= wbyte_r & acc_pkg::CONV_SEL_MASK;
      end
      if (wr_cmp) begin
        cmp_ctl_r <= {wbyte_r[acc_pkg::CMP_OFF_BIT], wbyte_r[acc_pkg::BANDGAP_BIT],
                      wbyte_r[acc_pkg::IRQ_EN_BIT], wbyte_r[acc_pkg::CAP_ROUTE_BIT],
                      wbyte_r[acc_pkg::EDGE_MODE_LSB +: 2]};
      end
      flag_r <= flag_nxt;
    end
  end

  // ****************************************
  // registered outputs to the pins and timer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_read_r <= '0;
      route_r    <= '0;
      capture_r  <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      pin_read_r <= pin_in & ~dig_dis_r;
      route_r    <= route_nxt;
      capture_r  <= cmp_sync & cmp_ctl_r.capture_route_enable;
      // built from the next flag so request and flag rise in one cycle
      irq_r      <= flag_nxt & cmp_ctl_r.irq_enable & global_irq_enable & ~irq_vector_taken;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= acc_pkg::RESP_OKAY;
      awaddr_r  <= '0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
    end else begin
      // readies reopen at the response handshake, so writes may run back to back
      if (aw_take) begin
        awready_r <= 1'b0;
        aw_got_r  <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (!aw_got_r && b_free) begin
        awready_r <= 1'b1;
      end
      if (w_take) begin
        wready_r <= 1'b0;
        w_got_r  <= 1'b1;
        wbyte_r  <= s_axi_wdata[7:0];
        wlane_r  <= s_axi_wstrb[0];
      end else if (!w_got_r && b_free) begin
        wready_r <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= is_mapped(awaddr_r) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  wire [7:0] cmp_rd = {cmp_ctl_r.power_off, cmp_ctl_r.bandgap_select, cmp_sync, flag_r,
                       cmp_ctl_r.irq_enable, cmp_ctl_r.capture_route_enable,
                       cmp_ctl_r.edge_mode_field};
  // live address decode: the byte is caught at the edge that takes the request
  // one read at a time: arready stays low until the answer is taken
  wire [7:0] rd_byte =
    (s_axi_araddr == acc_pkg::DIG_IN_DIS_ADDR)  ? 8'(dig_dis_r) :
    (s_axi_araddr == acc_pkg::CONV_CTL_B_ADDR)  ? conv_ctl_b_r :
    (s_axi_araddr == acc_pkg::CMP_CTL_STS_ADDR) ? cmp_rd :
    (s_axi_araddr == acc_pkg::CONV_SEL_ADDR)    ? conv_sel_r : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= acc_pkg::RESP_OKAY;
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, rd_byte};
      rresp_r   <= is_mapped(s_axi_araddr) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
    end else begin
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output below is a flop, never decode logic
  assign s_axi_awready      = awready_r;
  assign s_axi_wready       = wready_r;
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_arready      = arready_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rdata        = rdata_r;
  assign s_axi_rresp        = rresp_r;
  assign pin_read           = pin_read_r;
  assign digital_buffer_off = dig_dis_r;
  assign route              = route_r;
  assign converter_enable   = conv_sel_r[acc_pkg::CONV_EN_BIT];
  assign capture_in         = capture_r;
  assign cmp_irq            = irq_r;

endmodule : acc_top

// file: acc_pkg.sv
// constants and types for the analog comparator control block
package acc_pkg;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam logic [7:0] DIG_IN_DIS_IDX  = 8'h01;
  localparam logic [7:0] CONV_CTL_B_IDX  = 8'h03;
  localparam logic [7:0] CMP_CTL_STS_IDX = 8'h08;
  localparam logic [7:0] CONV_SEL_IDX    = 8'h0c;
  localparam logic [9:0] DIG_IN_DIS_ADDR  = {DIG_IN_DIS_IDX, 2'b00};
  localparam logic [9:0] CONV_CTL_B_ADDR  = {CONV_CTL_B_IDX, 2'b00};
  localparam logic [9:0] CMP_CTL_STS_ADDR = {CMP_CTL_STS_IDX, 2'b00};
  localparam logic [9:0] CONV_SEL_ADDR    = {CONV_SEL_IDX, 2'b00};
  localparam int         ADDR_W           = 10;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [7:0] DIG_IN_DIS_RST  = 8'h00;
  localparam logic [7:0] CONV_CTL_B_RST  = 8'h00;
  localparam logic [7:0] CONV_CTL_B_MASK = 8'hd7;
  localparam logic [7:0] CONV_SEL_MASK   = 8'h9f;

  // ****************************************
  // field positions
  // ****************************************
  localparam int NEG_MUX_EN_BIT   = 6;
  localparam int CONV_EN_BIT      = 7;
  localparam int CMP_OFF_BIT      = 7;
  localparam int BANDGAP_BIT      = 6;
  localparam int RESULT_BIT       = 5;
  localparam int FLAG_BIT         = 4;
  localparam int IRQ_EN_BIT       = 3;
  localparam int CAP_ROUTE_BIT    = 2;
  localparam int EDGE_MODE_LSB    = 0;
  localparam int CHAN_SEL_LSB     = 0;
  localparam int SYNC_STAGES      = 2;

  // ****************************************
  // edge modes and bus answers
  // ****************************************
  localparam logic [1:0] EDGE_TOGGLE   = 2'h0;
  localparam logic [1:0] EDGE_RESERVED = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_RISE     = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam logic [4:0] CHAN_LAST     = 5'h07;

  // comparator control fields
  typedef struct packed {
    logic       power_off;
    logic       bandgap_select;
    logic       irq_enable;
    logic       capture_route_enable;
    logic [1:0] edge_mode_field;
  } acc_cmp_ctl_t;

  // analog input routing handed to the analog front end
  typedef struct packed {
    logic       neg_from_converter;
    logic [2:0] neg_channel;
    logic       pos_from_bandgap;
    logic       cmp_power_off;
  } acc_route_t;

endpackage : acc_pkg

// file: acc_sync.sv
// two-flop synchroniser for the raw comparator output
`timescale 1ns/1ps
module acc_sync #(
  parameter int STAGES = acc_pkg::SYNC_STAGES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic [STAGES-1:0] chain_r;

  // first stage feeds only the next stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], din};
    end
  end

  assign dout = chain_r[STAGES-1];
endmodule : acc_sync

// file: acc_edge.sv
// comparator output event detector by edge mode
`timescale 1ns/1ps
module acc_edge (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       level,
  input  wire logic [1:0] mode,
  output logic            event_pulse
);
  logic prev_r;
  logic rise;
  logic fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
  // reserved mode raises no event
  assign event_pulse = (mode == acc_pkg::EDGE_TOGGLE) ? (rise | fall) :
                       (mode == acc_pkg::EDGE_FALL)   ? fall :
                       (mode == acc_pkg::EDGE_RISE)   ? rise : 1'b0;
endmodule : acc_edge

// file: acc_front_model.sv
// analog front end and timer capture unit facing the comparator control block
`timescale 1ns/1ps
module acc_front_model #(
  parameter logic [7:0] BANDGAP_LVL = 8'h80
) (
  input  wire logic                aclk,
  input  wire acc_pkg::acc_route_t route,
  input  wire logic [7:0]          pos_lvl,
  input  wire logic [7:0]          neg_lvl,
  input  wire logic [63:0]         chan_lvl,
  input  wire logic                capture_in,
  input  wire logic                capture_irq_enable,
  output logic                     cmp_raw,
  output logic [7:0]               cap_count
);
  logic [7:0] pos_v;
  logic [7:0] neg_v;
  logic       cap_q;
  // ****************************************
  // comparator inputs and decision
  // ****************************************
  assign pos_v = route.pos_from_bandgap ? BANDGAP_LVL : pos_lvl;
  assign neg_v = route.neg_from_converter ? chan_lvl[route.neg_channel*8 +: 8] : neg_lvl;
  // powered off comparator reads low, like the real cell
  assign cmp_raw = !route.cmp_power_off && (pos_v > neg_v);
  // ****************************************
  // timer capture front end
  // ****************************************
  initial cap_q = 1'b0;
  initial cap_count = 8'h00;
  always @(posedge aclk) begin
    cap_q <= capture_in;
    if (capture_in && !cap_q && capture_irq_enable) begin
      cap_count <= cap_count + 8'h01;
    end
  end
endmodule : acc_front_model

// file: acc_top_asserts.sv
// port-level assertions for the comparator control block
`timescale 1ns/1ps
module acc_top_asserts #(
  parameter int NUM_PINS = 8
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [9:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                cmp_raw,
  input wire logic                global_irq_enable,
  input wire logic                irq_vector_taken,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_read,
  input wire logic [NUM_PINS-1:0] digital_buffer_off,
  input wire acc_pkg::acc_route_t route,
  input wire logic                converter_enable,
  input wire logic                capture_in,
  input wire logic                cmp_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // helper: raw comparator history
  // ****************************************
  // left unreset on purpose: unknown history keeps quiet low
  logic [3:0] raw_h;
  always_ff @(posedge aclk) begin
    raw_h <= {raw_h[2:0], cmp_raw};
  end
  wire quiet = (raw_h == 4'h0) || (raw_h == 4'hf);
  wire bad_addr = !(s_axi_araddr inside {acc_pkg::DIG_IN_DIS_ADDR, acc_pkg::CONV_CTL_B_ADDR,
                                         acc_pkg::CMP_CTL_STS_ADDR, acc_pkg::CONV_SEL_ADDR});
  // ****************************************
  // assertions
  // ****************************************
  a_pin_read_mask: assert property (1'b1 |=>
    pin_read == ($past(pin_in) & ~$past(digital_buffer_off))) else $error("pin read not masked");
  a_conv_on_pin: assert property (converter_enable && $past(converter_enable)
    |-> !route.neg_from_converter) else $error("converter path used while converter on");
  a_irq_needs_gie: assert property (cmp_irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  a_vector_clears_irq: assert property (irq_vector_taken && quiet |=> !cmp_irq)
    else $error("irq stays after vector taken");
  a_capture_quiet_low: assert property (quiet && !raw_h[0] |-> !capture_in)
    else $error("capture high while comparator low");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_unmapped_error: assert property (s_axi_arvalid && s_axi_arready && bad_addr |=>
    s_axi_rresp == acc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
  c_vector: cover property (irq_vector_taken && cmp_irq);
  c_capture: cover property (capture_in);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == acc_pkg::RESP_SLVERR);
endmodule : acc_top_asserts

// file: analog_comparator_control_bench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module analog_comparator_control_bench;
  localparam logic [9:0] A_DID = acc_pkg::DIG_IN_DIS_ADDR;
  localparam logic [9:0] A_CMP = acc_pkg::CMP_CTL_STS_ADDR;
  localparam logic [9:0] A_SEL = acc_pkg::CONV_SEL_ADDR;
  logic        aclk, aresetn, cmp_raw, global_irq_enable, irq_vector_taken, capture_in;
  logic        converter_enable, cmp_irq, capture_irq_enable;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  pin_in, pin_read, digital_buffer_off, pos_lvl, neg_lvl, cap_count, rd;
  logic [63:0] chan_lvl;
  acc_pkg::acc_route_t route;
  int          err_total, checks;
  // ordinary rows: address, read back after writing ff, response
  logic [9:0]  ra [4] = '{A_DID, acc_pkg::CONV_CTL_B_ADDR, A_SEL, 10'h3fc};
  logic [7:0]  re [4] = '{8'hff, 8'hd7, 8'h9f, 8'h00};
  logic [1:0]  rr [4] = '{2'h0, 2'h0, 2'h0, 2'h2};
  // edge modes with expected flag after a rise and after a fall
  logic [1:0]  md [4] = '{acc_pkg::EDGE_TOGGLE, acc_pkg::EDGE_FALL, acc_pkg::EDGE_RISE,
                          acc_pkg::EDGE_RESERVED};
  logic        up [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic        dn [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  acc_top #(.NUM_PINS(8)) i_acc_top (.*);
  acc_front_model i_acc_front_model (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      err_total++;
      report_and_stop();
    end
  endtask : wr
  task automatic rdr(input logic [9:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      err_total++;
      report_and_stop();
    end
  endtask : rdr
  // sync two edges, event and flag one more, one more to see the flops
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask : settle
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {aresetn, global_irq_enable, irq_vector_taken, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    capture_irq_enable = 1'b1;
    pin_in = 8'hff;
    pos_lvl = 8'h00;
    neg_lvl = 8'h40;
    chan_lvl = 64'h00ff00ff00ff00ff;
    err_total = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rdr(ra[i]);
      `CHK("reset value", 8'h00, rd)
    end
    rdr(A_CMP);
    `CHK("status reset", 8'h00, rd)
    $display("end reset values");
    foreach (ra[i]) begin
      wr(ra[i], 8'hff, rs);
      `CHK("write resp", rr[i], rs)
      rdr(ra[i]);
      `CHK("read back", re[i], rd)
      `CHK("read resp", rr[i], rs)
    end
    settle();
    `CHK("conv on route", 2'b10, {converter_enable, route.neg_from_converter})
    `CHK("pins all off", 8'h00, pin_read)
    wr(A_DID, 8'h03, rs);
    wr(A_SEL, 8'h00, rs);
    settle();
    `CHK("pin mask", 8'hfc, pin_read)
    `CHK("buffer off", 8'h03, digital_buffer_off)
    pos_lvl <= 8'h80;
    for (int c = 0; c < 8; c++) begin
      wr(A_SEL, c[7:0], rs);
      settle();
      `CHK("channel", {1'b1, c[2:0]}, {route.neg_from_converter, route.neg_channel})
      rdr(A_CMP);
      `CHK("result", c[0], rd[5])
    end
    pos_lvl <= 8'h00;
    wr(A_SEL, 8'h09, rs);
    settle();
    `CHK("code nine", 1'b0, route.neg_from_converter)
    $display("end routing");
    global_irq_enable <= 1'b1;
    foreach (md[i]) begin
      wr(A_CMP, 8'h10 | {6'h0, md[i]}, rs);
      wr(A_CMP, 8'h18 | {6'h0, md[i]}, rs);
      pos_lvl <= 8'hff;
      settle();
      `CHK("irq up", up[i], cmp_irq)
      rdr(A_CMP);
      `CHK("flag up", up[i], rd[4])
      wr(A_CMP, 8'h18 | {6'h0, md[i]}, rs);
      rdr(A_CMP);
      `CHK("flag clear", 1'b0, rd[4])
      pos_lvl <= 8'h00;
      settle();
      `CHK("irq down", dn[i], cmp_irq)
      wr(A_CMP, 8'h10 | {6'h0, md[i]}, rs);
    end
    $display("end edge modes");
    wr(A_CMP, 8'h13, rs);
    wr(A_CMP, 8'h0b, rs);
    pos_lvl <= 8'hff;
    settle();
    `CHK("irq rise", 1'b1, cmp_irq)
    irq_vector_taken <= 1'b1;
    @(posedge aclk);
    irq_vector_taken <= 1'b0;
    settle();
    `CHK("vector clear", 1'b0, cmp_irq)
    pos_lvl <= 8'h00;
    global_irq_enable <= 1'b0;
    settle();
    pos_lvl <= 8'hff;
    settle();
    `CHK("irq masked", 1'b0, cmp_irq)
    global_irq_enable <= 1'b1;
    settle();
    `CHK("irq unmasked", 1'b1, cmp_irq)
    $display("end interrupt");
    wr(A_CMP, 8'h07, rs);
    settle();
    `CHK("capture on", 1'b1, capture_in)
    `CHK("captures", 8'h01, cap_count)
    wr(A_CMP, 8'h00, rs);
    settle();
    `CHK("capture off", 1'b0, capture_in)
    pos_lvl <= 8'h00;
    wr(A_CMP, 8'h40, rs);
    settle();
    rdr(A_CMP);
    `CHK("bandgap", 2'b11, {route.pos_from_bandgap, rd[5]})
    wr(A_CMP, 8'hc0, rs);
    settle();
    rdr(A_CMP);
    `CHK("power off", 2'b10, {route.cmp_power_off, rd[5]})
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(A_DID);
    `CHK("second reset", 8'h00, rd)
    $display("end power and reset");
    report_and_stop();
  end
endmodule : analog_comparator_control_bench
bind acc_top acc_top_asserts #(.NUM_PINS(NUM_PINS)) i_acc_top_asserts (.*);
